// ===== logic/fep_pkg.sv
// fep_pkg: constants, code tables and types of the 100 Mbps coding block
// assumes one 250 MHz core clock; both mii clocks are divided from it
// How it works
// - 10 Mbps half duplex, inhibit clear: transmit nibbles return on receive
// - no operational loopback at 100 Mbps, full duplex or inhibit set
// - test loopback silences the line side and loops mac data inside
// - test loopback at either speed, needs loop, full duplex, no autoneg
// - at 100 Mbps idle groups flow between frames while transmit enable is low
// - at 100 Mbps the line carries 5-bit groups, one per nibble
// - first two nibbles of a frame become J then K
// - later nibbles map to data groups until transmit enable drops
// - frame end sends T then R, then idle again
// - received J K pair becomes two preamble nibbles
// - at 100 Mbps preamble is always forwarded, never stripped
// - invalid groups received inside a frame raise receive error
// - group 00100 is the error symbol and is flagged
// - collision output follows the collision for its whole length
// - groups leave before scrambling and arrive already descrambled
// - mii clocks run 25 MHz at 100 Mbps and 2.5 MHz at 10
// - invalid symbol at 100 Mbps drives receive nibble 0101 with error
// - carrier sense rises on J K and falls on T R
package fep_pkg;
    localparam int unsigned CLK_HZ      = 250_000_000;
    localparam int unsigned MII_FAST_HZ = 25_000_000;
    localparam int unsigned MII_SLOW_HZ = 2_500_000;
    localparam int unsigned HALF_FAST   = CLK_HZ / (2 * MII_FAST_HZ);
    localparam int unsigned HALF_SLOW   = CLK_HZ / (2 * MII_SLOW_HZ);
    localparam int          DIV_W       = 7;

    localparam logic [4:0] CODE_IDLE = 5'h1f;
    localparam logic [4:0] CODE_J    = 5'h18;
    localparam logic [4:0] CODE_K    = 5'h11;
    localparam logic [4:0] CODE_T    = 5'h0d;
    localparam logic [4:0] CODE_R    = 5'h07;
    localparam logic [4:0] CODE_H    = 5'h04;
    // entry n sits at bits n*5 +: 5, nibble f first
    localparam logic [79:0] CODE_TABLE = {
        5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16, 5'h13, 5'h12,
        5'h0f, 5'h0e, 5'h0b, 5'h0a, 5'h15, 5'h14, 5'h09, 5'h1e};
    localparam logic [3:0] NIB_PRE = 4'h5;
    localparam logic [3:0] NIB_ERR = 4'h5;

    localparam logic [31:0] ADDR_CTRL      = 32'h0000_0000;
    localparam logic [31:0] ADDR_STAT      = 32'h0000_0004;
    localparam int          HTRANS_ACT_BIT = 1;
    localparam logic [2:0]  HSIZE_WORD     = 3'h2;
    localparam logic [7:0]  ERR_MAX        = 8'hff;

    typedef struct packed {
        logic inhibit;
        logic speed_100;
        logic aneg;
        logic fdx;
        logic loop;
    } fep_ctrl_t;
    localparam fep_ctrl_t CTRL_RESET = 5'h08;

    typedef struct packed {
        logic [7:0] err_cnt;
        logic [2:0] rsvd;
        logic       op_loop;
        logic       test_loop;
        logic       carrier;
        logic       col;
        logic       crs;
    } fep_stat_t;

    typedef struct packed {
        logic       en;
        logic [3:0] d;
    } fep_mii_tx_t;

    typedef struct packed {
        logic       dv;
        logic       er;
        logic [3:0] d;
    } fep_mii_rx_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_K    = 2'b01,
        TX_DATA = 2'b10,
        TX_R    = 2'b11
    } fep_tx_st_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_SSD2 = 2'b01,
        RX_DATA = 2'b10
    } fep_rx_st_t;
endpackage

// ===== logic/fep_codec.sv
// fep_codec: 4b5b data lookup in both directions, purely combinational
// assumes the table in fep_pkg; control groups are handled by the caller
`timescale 1ns/100ps
`default_nettype none
module fep_codec
    import fep_pkg::*;
(
    input  wire logic [3:0] nib_in,
    output logic      [4:0] code_out,
    input  wire logic [4:0] code_in,
    output logic      [3:0] nib_out,
    output logic            hit_out
);
    logic [15:0] hit_w;

    assign code_out = CODE_TABLE[nib_in*5 +: 5];

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_cmp
            assign hit_w[gi] = (code_in == CODE_TABLE[gi*5 +: 5]);
        end
    endgenerate

    assign hit_out = |hit_w;

    // table entries are unique, so or-ing the indices is exact
    always_comb begin
        nib_out = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (hit_w[i]) begin
                nib_out = nib_out | 4'(i);
            end
        end
    end
endmodule
`default_nettype wire

// ===== logic/fep_pcs_top.sv
// fep_pcs_top: mii side coding, loopbacks, carrier and collision, ahb regs
// assumes an external scrambler on the line ports and a mac on the mii pins
`timescale 1ns/100ps
`default_nettype none
module fep_pcs_top
    import fep_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hwdata_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    output logic             mii_tx_clk_out,
    output logic             mii_rx_clk_out,
    input  wire logic [3:0]  mac_transmit_nibbles_in,
    input  wire logic        mii_tx_en_in,
    output logic      [3:0]  mac_receive_nibbles_out,
    output logic             mii_rx_dv_out,
    output logic             mii_rx_er_out,
    output logic             mii_crs_out,
    output logic             mii_col_out,
    output logic      [4:0]  line_tx_code_out,
    output logic             line_tx_en_out,
    input  wire logic [4:0]  line_rx_code_in
);
    // bus slave state
    fep_ctrl_t    ctrl_q;
    logic         wr_pend_q;
    logic [31:0]  wr_addr_q;
    logic [31:0]  hrdata_q;
    logic         hreadyout_q;
    // clock divider
    logic [DIV_W-1:0] div_q;
    logic             tx_clk_q;
    logic             rx_clk_q;
    // synchronisers
    fep_mii_tx_t  tx_m1_q;
    fep_mii_tx_t  tx_s_q;
    logic [4:0]   rx_m1_q;
    logic [4:0]   rx_s_q;
    // coding paths
    fep_mii_tx_t  tx_cap_q;
    fep_tx_st_t   tx_st_q;
    fep_tx_st_t   tx_st_d;
    logic [4:0]   tx_code_q;
    logic [4:0]   tx_code_d;
    logic         line_en_q;
    fep_rx_st_t   rx_st_q;
    fep_rx_st_t   rx_st_d;
    logic [4:0]   rx_last_q;
    fep_mii_rx_t  rx_q;
    fep_mii_rx_t  rx_d;
    logic         car_q;
    logic         car_d;
    logic         crs_q;
    logic         col_q;
    logic [7:0]   err_cnt_q;

    // ---------------- bus decode ----------------
    wire ahb_sel_w = hsel_in && hready_in && htrans_in[HTRANS_ACT_BIT]
                     && (hsize_in == HSIZE_WORD);
    wire ahb_rd_w  = ahb_sel_w && !hwrite_in;
    wire ahb_wr_w  = ahb_sel_w && hwrite_in;
    wire ctrl_wr_w = wr_pend_q && (wr_addr_q == ADDR_CTRL);

    // ---------------- mode decode ----------------
    wire test_loop_w = ctrl_q.loop && ctrl_q.fdx && !ctrl_q.aneg;
    wire op_loop_w   = !ctrl_q.speed_100 && !ctrl_q.fdx
                       && !ctrl_q.inhibit && !test_loop_w;
    wire fast_w      = ctrl_q.speed_100;
    wire loop_w      = test_loop_w || op_loop_w;
    wire tx_path_w   = fast_w && !test_loop_w;
    wire rx_path_w   = fast_w && !loop_w;

    fep_stat_t stat_w;
    assign stat_w.err_cnt   = err_cnt_q;
    assign stat_w.rsvd      = '0;
    assign stat_w.op_loop   = op_loop_w;
    assign stat_w.test_loop = test_loop_w;
    assign stat_w.carrier   = car_q;
    assign stat_w.col       = col_q;
    assign stat_w.crs       = crs_q;

    wire [31:0] rd_mux_w = (haddr_in == ADDR_CTRL) ? 32'(ctrl_q) :
                           (haddr_in == ADDR_STAT) ? 32'(stat_w) : '0;

    // ---------------- mii clock divider ----------------
    wire [DIV_W-1:0] half_w = fast_w ? DIV_W'(HALF_FAST)
                                     : DIV_W'(HALF_SLOW);
    wire div_wrap_w = (div_q >= (half_w - DIV_W'(1)));
    wire rise_w     = div_wrap_w && !tx_clk_q;
    wire fall_w     = div_wrap_w && tx_clk_q;
    wire clk_nxt_w  = div_wrap_w ? !tx_clk_q : tx_clk_q;

    // ---------------- codec ----------------
    logic [4:0] enc_code_w;
    logic [3:0] dec_nib_w;
    logic       dec_hit_w;

    fep_codec u_codec (
        .nib_in   (tx_s_q.d),
        .code_out (enc_code_w),
        .code_in  (rx_last_q),
        .nib_out  (dec_nib_w),
        .hit_out  (dec_hit_w)
    );

    wire ssd_seen_w = (rx_last_q == CODE_J) && (rx_s_q == CODE_K);
    wire esd_seen_w = (rx_last_q == CODE_T) && (rx_s_q == CODE_R);
    wire err_sym_w  = (rx_last_q == CODE_H);

    // ---------------- transmit encoder ----------------
    always_comb begin
        tx_st_d   = tx_st_q;
        tx_code_d = CODE_IDLE;
        case (tx_st_q)
            TX_IDLE: begin
                if (tx_s_q.en) begin
                    tx_code_d = CODE_J;
                    tx_st_d   = TX_K;
                end
            end
            TX_K: begin
                tx_code_d = CODE_K;
                tx_st_d   = TX_DATA;
            end
            TX_DATA: begin
                if (tx_s_q.en) begin
                    tx_code_d = enc_code_w;
                end else begin
                    tx_code_d = CODE_T;
                    tx_st_d   = TX_R;
                end
            end
            TX_R: begin
                tx_code_d = CODE_R;
                tx_st_d   = TX_IDLE;
            end
            default: begin
                tx_st_d = TX_IDLE;
            end
        endcase
    end

    // ---------------- receive decoder ----------------
    always_comb begin
        rx_st_d = rx_st_q;
        rx_d    = '0;
        car_d   = car_q;
        case (rx_st_q)
            RX_IDLE: begin
                if (ssd_seen_w) begin
                    rx_d.dv = 1'b1;
                    rx_d.d  = NIB_PRE;
                    car_d   = 1'b1;
                    rx_st_d = RX_SSD2;
                end
            end
            RX_SSD2: begin
                rx_d.dv = 1'b1;
                rx_d.d  = NIB_PRE;
                rx_st_d = RX_DATA;
            end
            RX_DATA: begin
                if (esd_seen_w) begin
                    car_d   = 1'b0;
                    rx_st_d = RX_IDLE;
                end else if (rx_last_q == CODE_IDLE) begin
                    // stream lost its end pair: one error, then quiet
                    rx_d.er = 1'b1;
                    car_d   = 1'b0;
                    rx_st_d = RX_IDLE;
                end else if (dec_hit_w && !err_sym_w) begin
                    rx_d.dv = 1'b1;
                    rx_d.d  = dec_nib_w;
                end else begin
                    rx_d.dv = 1'b1;
                    rx_d.er = 1'b1;
                    rx_d.d  = NIB_ERR;
                end
            end
            default: begin
                rx_st_d = RX_IDLE;
            end
        endcase
    end

    // ---------------- bus registers ----------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl_q      <= CTRL_RESET;
            wr_pend_q   <= 1'b0;
            wr_addr_q   <= '0;
            hrdata_q    <= '0;
            hreadyout_q <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
            wr_pend_q   <= ahb_wr_w;
            wr_addr_q   <= haddr_in;
            if (ahb_rd_w) begin
                hrdata_q <= rd_mux_w;
            end
            if (ctrl_wr_w) begin
                ctrl_q <= fep_ctrl_t'(hwdata_in[$bits(fep_ctrl_t)-1:0]);
            end
        end
    end

    // ---------------- divider and synchronisers ----------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            div_q    <= '0;
            tx_clk_q <= 1'b0;
            rx_clk_q <= 1'b0;
            tx_m1_q  <= '0;
            tx_s_q   <= '0;
            rx_m1_q  <= CODE_IDLE;
            rx_s_q   <= CODE_IDLE;
        end else begin
            div_q    <= div_wrap_w ? '0 : div_q + DIV_W'(1);
            tx_clk_q <= clk_nxt_w;
            rx_clk_q <= clk_nxt_w;
            tx_m1_q  <= {mii_tx_en_in, mac_transmit_nibbles_in};
            tx_s_q   <= tx_m1_q;
            rx_m1_q  <= line_rx_code_in;
            rx_s_q   <= rx_m1_q;
        end
    end

    // ---------------- transmit side ----------------
    // mac values settle a full half period before the next rising edge
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tx_cap_q  <= '0;
            tx_st_q   <= TX_IDLE;
            tx_code_q <= CODE_IDLE;
            line_en_q <= 1'b0;
        end else begin
            line_en_q <= !test_loop_w;
            if (rise_w) begin
                tx_cap_q <= tx_s_q;
            end
            if (!tx_path_w) begin
                tx_st_q   <= TX_IDLE;
                tx_code_q <= CODE_IDLE;
            end else if (rise_w) begin
                tx_st_q   <= tx_st_d;
                tx_code_q <= tx_code_d;
            end
        end
    end

    // ---------------- receive side, updated mid period ----------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rx_st_q   <= RX_IDLE;
            rx_last_q <= CODE_IDLE;
            rx_q      <= '0;
            car_q     <= 1'b0;
            err_cnt_q <= '0;
        end else if (fall_w) begin
            rx_last_q <= rx_s_q;
            if (loop_w) begin
                rx_st_q <= RX_IDLE;
                car_q   <= 1'b0;
                rx_q    <= {tx_cap_q.en, 1'b0, tx_cap_q.d};
            end else if (rx_path_w) begin
                rx_st_q <= rx_st_d;
                car_q   <= car_d;
                rx_q    <= rx_d;
                if (rx_d.er && (err_cnt_q != ERR_MAX)) begin
                    err_cnt_q <= err_cnt_q + 8'h01;
                end
            end else begin
                rx_st_q <= RX_IDLE;
                car_q   <= 1'b0;
                rx_q    <= '0;
            end
        end
    end

    // ---------------- carrier and collision ----------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            crs_q <= 1'b0;
            col_q <= 1'b0;
        end else begin
            crs_q <= car_q || (tx_s_q.en && (!ctrl_q.fdx || test_loop_w));
            col_q <= !ctrl_q.fdx && tx_s_q.en && car_q;
        end
    end

    assign hrdata_out              = hrdata_q;
    assign hreadyout_out           = hreadyout_q;
    assign hresp_out               = 1'b0 & hreadyout_q;
    assign mii_tx_clk_out          = tx_clk_q;
    assign mii_rx_clk_out          = rx_clk_q;
    assign mac_receive_nibbles_out = rx_q.d;
    assign mii_rx_dv_out           = rx_q.dv;
    assign mii_rx_er_out           = rx_q.er;
    assign mii_crs_out             = crs_q;
    assign mii_col_out             = col_q;
    assign line_tx_code_out        = tx_code_q;
    assign line_tx_en_out          = line_en_q;

    // ---------------- checks ----------------
    default clocking dcb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);

    tx_idle_a: assert property (
        (rise_w && tx_path_w && tx_st_q == TX_IDLE && !tx_s_q.en)
        |=> (tx_code_q == CODE_IDLE))
        else $error("idle not sent while transmit enable low");

    tx_ssd_a: assert property (
        (rise_w && tx_path_w && tx_st_q == TX_IDLE && tx_s_q.en
         && $stable(ctrl_q))
        |=> (tx_code_q == CODE_J) ##10 (tx_code_q == CODE_K))
        else $error("start pair not J then K");

    tx_esd_a: assert property (
        (rise_w && tx_path_w && tx_st_q == TX_DATA && !tx_s_q.en
         && $stable(ctrl_q))
        |=> (tx_code_q == CODE_T) ##10 (tx_code_q == CODE_R))
        else $error("end pair not T then R");

    rx_pre_a: assert property (
        (fall_w && rx_path_w && rx_st_q == RX_IDLE && ssd_seen_w
         && $stable(ctrl_q))
        |=> (rx_q.dv && rx_q.d == NIB_PRE)
            ##10 (rx_q.dv && rx_q.d == NIB_PRE))
        else $error("start pair not replaced by two preamble nibbles");

    rx_err_a: assert property (
        (fall_w && rx_path_w && rx_st_q == RX_DATA && !dec_hit_w
         && rx_last_q != CODE_T && rx_last_q != CODE_IDLE)
        |=> (rx_q.er && rx_q.d == NIB_ERR))
        else $error("invalid group without error and 0101");

    no_oploop_a: assert property (
        (ctrl_q.speed_100 || ctrl_q.fdx || ctrl_q.inhibit) |-> !op_loop_w)
        else $error("operational loopback in a forbidden mode");

    line_off_a: assert property (
        test_loop_w ##1 test_loop_w |-> !line_en_q
                                        && tx_code_q == CODE_IDLE)
        else $error("line side active during test loopback");

    col_follow_a: assert property (
        (!ctrl_q.fdx && tx_s_q.en && car_q) |=> col_q)
        else $error("collision not shown");

    clk_fast_a: assert property (
        ($rose(tx_clk_q) && fast_w && $stable(ctrl_q))
        |-> tx_clk_q[*5] ##1 (!tx_clk_q || !fast_w))
        else $error("fast mii clock high phase not five cycles");
endmodule
`default_nettype wire

// ===== verification/fep_mac_model.sv
// fep_mac_model: mac side of the mii, sends nibble frames, logs receive
// assumes both mii clocks come from the block and are seen by clk_in
`timescale 1ns/100ps
`default_nettype none
module fep_mac_model (
    input  wire logic       clk_in,
    input  wire logic       tx_clk_in,
    input  wire logic       rx_clk_in,
    input  wire logic [3:0] rx_d_in,
    input  wire logic       rx_dv_in,
    input  wire logic       rx_er_in,
    output logic      [3:0] tx_d_out,
    output logic            tx_en_out
);
    logic       tx_clk_q;
    logic       rx_clk_q;
    logic [5:0] rx_log[$];

    initial begin
        tx_d_out  = 4'h0;
        tx_en_out = 1'b0;
        tx_clk_q  = 1'b0;
        rx_clk_q  = 1'b0;
    end

    // {er, dv, d} taken at each rising receive clock, as a mac would
    always @(posedge clk_in) begin
        tx_clk_q <= tx_clk_in;
        rx_clk_q <= rx_clk_in;
        if (rx_clk_in && !rx_clk_q) begin
            rx_log.push_back({rx_er_in, rx_dv_in, rx_d_in});
        end
    end

    // returns one core cycle after a rising transmit clock
    task automatic tx_edge();
        do @(posedge clk_in); while (!(tx_clk_in && !tx_clk_q));
    endtask

    task automatic send(input logic [3:0] nib[$]);
        foreach (nib[k]) begin
            tx_edge();
            tx_en_out <= 1'b1;
            tx_d_out  <= nib[k];
        end
        tx_edge();
        tx_en_out <= 1'b0;
        // released data must not look like the last nibble
        tx_d_out  <= ~tx_d_out;
    endtask
endmodule
`default_nettype wire

// ===== verification/fep_pcs_tb_top.sv
// fep_pcs_tb_top: self-checking bench for coding, loopbacks and registers
// assumes fep_mac_model on the mii pins and the bench driving the line
`timescale 1ns/100ps
`default_nettype none
module fep_pcs_tb_top;
    localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15,
        5'h0a, 5'h0b, 5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17,
        5'h1a, 5'h1b, 5'h1c, 5'h1d};
    localparam logic [4:0] BAD [11] = '{5'h00, 5'h01, 5'h02, 5'h03,
        5'h05, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h19, 5'h04};
    // ctrl values and the loopback each gives: 1 operational, 2 test
    localparam logic [4:0] MODE [8] = '{5'h00, 5'h10, 5'h02, 5'h08,
        5'h0b, 5'h03, 5'h07, 5'h09};
    localparam int         KIND [8] = '{1, 0, 0, 0, 2, 2, 0, 0};

    logic        clk_in    = 1'b0;
    logic        arst_n_in = 1'b0;
    logic        hsel, hwrite, hresp;
    logic [31:0] haddr, hwdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize, hsz;
    logic [4:0]  lrx;
    logic        tclk_q    = 1'b0;
    logic        col_seen  = 1'b0;
    logic        crs_seen  = 1'b0;
    logic [31:0] hrdata, rd, st0;
    logic        hready, tx_clk, rx_clk, tx_en, rx_dv, rx_er;
    logic        crs, col, ltx_en;
    logic [3:0]  txd, rxd;
    logic [4:0]  ltx;
    logic [4:0]  txl[$], cq[$], good[$];
    logic [3:0]  frm[$], lf[$];
    logic [5:0]  e[$], ge[$], le[$], nil[$];
    int          pc      = 0;
    int          per     = 0;
    int          fails   = 0;
    int          checked = 0;
    int          n;

    fep_pcs_top u_dut (
        .clk_in                  (clk_in),
        .arst_n_in               (arst_n_in),
        .hsel_in                 (hsel),
        .haddr_in                (haddr),
        .htrans_in               (htrans),
        .hwrite_in               (hwrite),
        .hsize_in                (hsize),
        .hready_in               (hready),
        .hwdata_in               (hwdata),
        .hrdata_out              (hrdata),
        .hreadyout_out           (hready),
        .hresp_out               (hresp),
        .mii_tx_clk_out          (tx_clk),
        .mii_rx_clk_out          (rx_clk),
        .mac_transmit_nibbles_in (txd),
        .mii_tx_en_in            (tx_en),
        .mac_receive_nibbles_out (rxd),
        .mii_rx_dv_out           (rx_dv),
        .mii_rx_er_out           (rx_er),
        .mii_crs_out             (crs),
        .mii_col_out             (col),
        .line_tx_code_out        (ltx),
        .line_tx_en_out          (ltx_en),
        .line_rx_code_in         (lrx)
    );

    fep_mac_model u_mac (
        .clk_in    (clk_in),
        .tx_clk_in (tx_clk),
        .rx_clk_in (rx_clk),
        .rx_d_in   (rxd),
        .rx_dv_in  (rx_dv),
        .rx_er_in  (rx_er),
        .tx_d_out  (txd),
        .tx_en_out (tx_en)
    );

    always #2 clk_in = ~clk_in;

    // line groups taken on falling transmit clock, period in core cycles
    always @(posedge clk_in) begin
        tclk_q <= tx_clk;
        if (col) begin
            col_seen <= 1'b1;
        end
        if (crs) begin
            crs_seen <= 1'b1;
        end
        if (!tx_clk && tclk_q) begin
            txl.push_back(ltx);
        end
        if (tx_clk && !tclk_q) begin
            per <= pc + 1;
            pc  <= 0;
        end else begin
            pc <= pc + 1;
        end
    end

    task automatic conclude();
        if (fails == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rdat);
        @(posedge clk_in);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        hsize  <= hsz;
        do @(posedge clk_in); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk_in); while (hready !== 1'b1);
        rdat = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic line_send(input logic [4:0] c[$]);
        foreach (c[k]) begin
            u_mac.tx_edge();
            lrx <= c[k];
        end
        u_mac.tx_edge();
        lrx <= 5'h1f;
    endtask

    task automatic rx_chk(input string what, input logic [5:0] x[$]);
        int j;
        logic tail;
        j = 0;
        while (j < u_mac.rx_log.size() && u_mac.rx_log[j][4] !== 1'b1) j++;
        foreach (x[k]) begin
            chk(what, {26'h0, x[k]}, {26'h0, u_mac.rx_log[j + k]});
        end
        n = j + x.size();
        tail = (n < u_mac.rx_log.size()) ? u_mac.rx_log[n][4] : 1'b0;
        chk(what, 32'h0, {31'h0, tail});
    endtask

    initial begin
        #200000;
        fails++;
        conclude();
    end

    initial begin
        hsel   <= 1'b0;
        haddr  <= 32'h0;
        htrans <= 2'h0;
        hwrite <= 1'b0;
        hwdata <= 32'h0;
        hsize  <= 3'h2;
        hsz     = 3'h2;
        lrx    <= 5'h1f;
        repeat (12) @(posedge clk_in);
        arst_n_in <= 1'b1;
        ahb(1'b0, 32'h0, 32'h0, rd);
        chk("ctrl reset", 32'h08, rd);
        ahb(1'b1, 32'h8, 32'hffff_ffff, rd);
        ahb(1'b0, 32'h8, 32'h0, rd);
        chk("unmapped read", 32'h0, rd);
        ahb(1'b1, 32'h4, 32'hffff_ffff, rd);
        ahb(1'b0, 32'h4, 32'h0, st0);
        chk("stat read only", 32'h0, st0 & 32'hffff_ff00);
        // a byte sized write must leave ctrl alone
        hsz = 3'h0;
        ahb(1'b1, 32'h0, 32'h0, rd);
        hsz = 3'h2;
        ahb(1'b0, 32'h0, 32'h0, rd);
        chk("byte write", 32'h08, rd);
        // transmit: two preamble nibbles, every data nibble, then d
        frm = '{4'h5, 4'h5};
        good = '{5'h18, 5'h11};
        ge = '{6'h15, 6'h15};
        for (int k = 0; k < 16; k++) begin
            frm.push_back(4'(k));
            good.push_back(ENC[k]);
            ge.push_back({2'b01, 4'(k)});
        end
        frm.push_back(4'hd);
        good.push_back(5'h0d);
        good.push_back(5'h07);
        txl.delete();
        u_mac.send(frm);
        repeat (60) @(posedge clk_in);
        n = 0;
        while (n < txl.size() && txl[n] === 5'h1f) n++;
        chk("idle lead", 32'h1, {31'h0, n > 0});
        chk("code j", 32'h18, {27'h0, txl[n]});
        chk("code k", 32'h11, {27'h0, txl[n + 1]});
        for (int k = 2; k < 19; k++) begin
            chk("data code", {27'h0, ENC[frm[k]]}, {27'h0, txl[n + k]});
        end
        chk("code t", 32'h0d, {27'h0, txl[n + 19]});
        chk("code r", 32'h07, {27'h0, txl[n + 20]});
        chk("idle after", 32'h1f, {27'h0, txl[n + 21]});
        // receive a clean frame
        u_mac.rx_log.delete();
        crs_seen = 1'b0;
        line_send(good);
        repeat (60) @(posedge clk_in);
        rx_chk("rx frame", ge);
        chk("crs seen", 32'h1, {31'h0, crs_seen});
        chk("crs after", 32'h0, {31'h0, crs});
        // every invalid group and the error symbol inside a frame
        cq = '{5'h18, 5'h11};
        e = '{6'h15, 6'h15};
        foreach (BAD[k]) begin
            cq.push_back(BAD[k]);
            e.push_back(6'h35);
        end
        cq.push_back(5'h0d);
        cq.push_back(5'h07);
        u_mac.rx_log.delete();
        line_send(cq);
        repeat (60) @(posedge clk_in);
        rx_chk("rx invalid", e);
        ahb(1'b0, 32'h4, 32'h0, rd);
        chk("error count", {24'h0, st0[15:8] + 8'd11}, {24'h0, rd[15:8]});
        // transmit while receiving in half duplex
        col_seen = 1'b0;
        fork
            u_mac.send(frm);
            line_send(good);
        join
        repeat (60) @(posedge clk_in);
        chk("col seen", 32'h1, {31'h0, col_seen});
        chk("col after", 32'h0, {31'h0, col});
        // speeds, duplex, inhibit and loopback requests
        lf = '{4'h5, 4'h5, 4'hd, 4'ha, 4'h3};
        le = '{6'h15, 6'h15, 6'h1d, 6'h1a, 6'h13};
        foreach (MODE[m]) begin
            ahb(1'b1, 32'h0, {27'h0, MODE[m]}, rd);
            repeat (3) u_mac.tx_edge();
            chk("clock period", MODE[m][3] ? 32'd10 : 32'd100, 32'(per));
            u_mac.rx_log.delete();
            txl.delete();
            u_mac.send(lf);
            repeat (3) u_mac.tx_edge();
            if (KIND[m] != 0) begin
                rx_chk("loopback", le);
            end else begin
                rx_chk("no loopback", nil);
            end
            chk("line enable", {31'h0, KIND[m] != 2}, {31'h0, ltx_en});
            n = 0;
            foreach (txl[k]) begin
                if (txl[k] !== 5'h1f) begin
                    n++;
                end
            end
            chk("line groups", {31'h0, KIND[m] != 2 && MODE[m][3]},
                {31'h0, n > 0});
            ahb(1'b0, 32'h4, 32'h0, rd);
            chk("loop state", {30'h0, KIND[m] == 1, KIND[m] == 2},
                {30'h0, rd[4:3]});
        end
        conclude();
    end
endmodule
`default_nettype wire
